// ==== shared/didb_pkg.sv ====
package didb_pkg;
   // Geometry of the block
   localparam int DIDB_NUM_INPUTS = 4;
   localparam int DIDB_ADDR_W = 16;
   localparam int DIDB_DATA_W = 16;
   localparam int DIDB_CODE_W = 3;
   localparam int DIDB_CNT_W = 18;

   // Parameter addresses of the four filter settings
   localparam logic [DIDB_ADDR_W-1:0] DIDB_ADDR_INPUT_TWO = 16'h0844;
   localparam logic [DIDB_ADDR_W-1:0] DIDB_ADDR_INPUT_THREE = 16'h0846;
   localparam logic [DIDB_ADDR_W-1:0] DIDB_ADDR_INPUT_FOUR = 16'h0848;
   localparam logic [DIDB_ADDR_W-1:0] DIDB_ADDR_INPUT_FIVE = 16'h084A;

   // Setting codes
   localparam logic [DIDB_DATA_W-1:0] DIDB_CODE_BYPASS = 16'h0000;
   localparam logic [DIDB_DATA_W-1:0] DIDB_CODE_MAX = 16'h0006;
   localparam logic [DIDB_DATA_W-1:0] DIDB_SETTING_RESET = 16'h0006;

   // Filter time step and its length in clock cycles
   localparam int DIDB_CLK_KHZ = 125000;
   localparam int DIDB_STEP_US = 250;
   localparam int DIDB_STEP_CYCLES = DIDB_STEP_US * DIDB_CLK_KHZ / 1000;
endpackage

// ==== hdl/didb_filter.sv ====
`timescale 1ns/1ps
// One debounce channel: output follows input after a stable hold time, or on the next cycle when the code is bypass
module didb_filter
   import didb_pkg::*;
#(
   parameter logic [DIDB_CNT_W-1:0] STEP_CYC = DIDB_CNT_W'(DIDB_STEP_CYCLES)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic din,
   input wire logic [DIDB_CODE_W-1:0] code,
   output logic dout_r
);
   logic [DIDB_CNT_W-1:0] count_r;
   logic [DIDB_CNT_W-1:0] count_nxt;
   logic dout_nxt;
   wire bypass_w = (code == DIDB_CODE_W'(DIDB_CODE_BYPASS));
   wire differ_w = (din != dout_r);
   // Live code, so a new setting acts on the next cycle
   wire [DIDB_CNT_W-1:0] limit_w = DIDB_CNT_W'(code * STEP_CYC);
   wire [DIDB_CNT_W:0] inc_w = {1'b0, count_r} + 1'b1;
   // >= so a shortened time mid-count still ends the wait
   wire flip_w = differ_w && (inc_w >= {1'b0, limit_w});

   // Next state: bypass copies, filter waits out the hold time
   always_comb begin
      if (bypass_w) begin
         dout_nxt = din;
         count_nxt = '0;
      end else if (!differ_w || flip_w) begin
         dout_nxt = flip_w ? din : dout_r;
         count_nxt = '0;
      end else begin
         dout_nxt = dout_r;
         count_nxt = inc_w[DIDB_CNT_W-1:0];
      end
   end

   // State registers
   always_ff @(posedge clock) begin
      if (rst) begin
         dout_r <= 1'b0;
         count_r <= '0;
      end else begin
         dout_r <= dout_nxt;
         count_r <= count_nxt;
      end
   end

   // Checks on the channel
   AST_BYPASS_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
      bypass_w |=> dout_r == $past(din))
      else $error("bypass output did not follow input");
   AST_NO_EARLY_CHANGE: assert property (@(posedge clock) disable iff (rst)
      (!bypass_w && differ_w && inc_w < {1'b0, limit_w}) |=> $stable(dout_r))
      else $error("filtered output changed before hold time");
   // Code settled two cycles, since a shortened time may flip at once
   AST_HOLD_TIME: assert property (@(posedge clock) disable iff (rst)
      (!bypass_w && $changed(dout_r) && $stable(code) && $past(code, 2) == code) |->
         ($past(count_r) == DIDB_CNT_W'(code * STEP_CYC - 1'b1)))
      else $error("filter time not code times step");
endmodule

// ==== hdl/didb_top.sv ====
`timescale 1ns/1ps
module didb_top
   import didb_pkg::*;
#(
   parameter logic [DIDB_CNT_W-1:0] STEP_CYC = DIDB_CNT_W'(DIDB_STEP_CYCLES)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic power_stage_en,
   input wire logic signal_input_two,
   input wire logic signal_input_three,
   input wire logic signal_input_four,
   input wire logic signal_input_five,
   input wire logic [DIDB_ADDR_W-1:0] param_addr,
   input wire logic param_wr,
   input wire logic param_rd,
   input wire logic [DIDB_DATA_W-1:0] param_wdata,
   output logic [DIDB_DATA_W-1:0] param_rdata_r,
   output logic param_ack_r,
   output logic param_refused_r,
   output logic filtered_two,
   output logic filtered_three,
   output logic filtered_four,
   output logic filtered_five
);
   localparam int N = DIDB_NUM_INPUTS;

   // Address table, one entry per channel
   wire [DIDB_ADDR_W-1:0] addr_w [N];
   assign addr_w[0] = DIDB_ADDR_INPUT_TWO;
   assign addr_w[1] = DIDB_ADDR_INPUT_THREE;
   assign addr_w[2] = DIDB_ADDR_INPUT_FOUR;
   assign addr_w[3] = DIDB_ADDR_INPUT_FIVE;

   // Raw pins gathered into a vector
   wire [N-1:0] raw_w = {signal_input_five, signal_input_four, signal_input_three, signal_input_two};

   logic [DIDB_DATA_W-1:0] setting_r [N];
   logic [N-1:0] sync1_r;
   logic [N-1:0] sync2_r;
   logic [N-1:0] sync3_r;
   logic [N-1:0] stable_r;
   logic [N-1:0] filt_w;
   logic [N-1:0] hit_w;
   logic [DIDB_DATA_W-1:0] rsel_w;

   // Write acceptance; power stage lock and range check
   // Out-of-range data is refused, not clamped, so a read shows what landed
   wire in_range_w = (param_wdata <= DIDB_CODE_MAX);
   wire unlocked_w = !power_stage_en;
   wire mapped_w = |hit_w;
   wire wr_ok_w = param_wr && mapped_w && unlocked_w && in_range_w;
   wire refuse_w = (param_wr && !(mapped_w && unlocked_w && in_range_w)) || (param_rd && !mapped_w);

   // Decode, setting register and filter per channel
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         assign hit_w[g] = (param_addr == addr_w[g]);

         // Own setting register per channel
         always_ff @(posedge clock) begin
            if (rst) begin
               setting_r[g] <= DIDB_SETTING_RESET;
            end else if (wr_ok_w && hit_w[g]) begin
               setting_r[g] <= param_wdata;
            end
         end

         didb_filter #(
            .STEP_CYC(STEP_CYC)
         ) u_filter (
            .clock(clock),
            .rst(rst),
            .din(stable_r[g]),
            .code(setting_r[g][DIDB_CODE_W-1:0]),
            .dout_r(filt_w[g])
         );

         // Per-channel setting checks
         AST_RESET_VALUE: assert property (@(posedge clock)
            rst |=> setting_r[g] == DIDB_SETTING_RESET)
            else $error("setting not at factory value after reset");
         AST_RANGE_KEPT: assert property (@(posedge clock) disable iff (rst)
            setting_r[g] <= DIDB_CODE_MAX)
            else $error("setting outside accepted range");
         AST_LOCKED_WHILE_POWERED: assert property (@(posedge clock) disable iff (rst)
            power_stage_en |=> $stable(setting_r[g]))
            else $error("setting changed while power stage enabled");
         AST_WRITE_APPLIES: assert property (@(posedge clock) disable iff (rst)
            (param_wr && hit_w[g] && !power_stage_en && param_wdata <= DIDB_CODE_MAX)
               |=> setting_r[g] == $past(param_wdata) && u_filter.code == $past(param_wdata[DIDB_CODE_W-1:0]))
            else $error("accepted setting not applied next cycle");
         AST_OTHERS_UNTOUCHED: assert property (@(posedge clock) disable iff (rst)
            !(param_wr && hit_w[g]) |=> $stable(setting_r[g]))
            else $error("setting changed by access to another address");
         AST_RANGE_REFUSED_KEEPS: assert property (@(posedge clock) disable iff (rst)
            (param_wr && hit_w[g] && param_wdata > DIDB_CODE_MAX) |=> $stable(setting_r[g]))
            else $error("out-of-range write changed a setting");
         // Channel wiring: own setting, own pin
         AST_BYPASS_OWN_PIN: assert property (@(posedge clock) disable iff (rst)
            (setting_r[g] == DIDB_CODE_BYPASS) |=> filt_w[g] == $past(stable_r[g]))
            else $error("bypassed channel did not follow its own pin");
         AST_MOVES_TO_PIN: assert property (@(posedge clock) disable iff (rst)
            $changed(filt_w[g]) |-> filt_w[g] == $past(stable_r[g]))
            else $error("filtered output moved away from its pin level");

         // A level is taken only once stages two and three agree
         AST_SYNC_AGREED: assert property (@(posedge clock) disable iff (rst)
            $changed(stable_r[g]) |-> $past(sync2_r[g]) == $past(sync3_r[g]) && stable_r[g] == $past(sync3_r[g]))
            else $error("pin level taken before synchroniser stages agreed");
      end
   endgenerate

   // Read selection, zero for unmapped addresses
   // Addresses are distinct, so at most one hit wins
   always_comb begin
      rsel_w = '0;
      for (int i = 0; i < N; i++) begin
         if (hit_w[i]) begin
            rsel_w = setting_r[i];
         end
      end
   end

   // Pin synchroniser; stage two and three must agree
   // Stage one may still be settling, so nothing else reads it
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= raw_w;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Agreed level, held while the stages disagree
   wire [N-1:0] agree_w = ~(sync2_r ^ sync3_r);
   always_ff @(posedge clock) begin
      if (rst) begin
         stable_r <= '0;
      end else begin
         stable_r <= (agree_w & sync3_r) | (~agree_w & stable_r);
      end
   end

   // Parameter port answers one cycle after the strobe
   // Read data holds between reads, so a slow master may fetch it late
   always_ff @(posedge clock) begin
      if (rst) begin
         param_rdata_r <= '0;
         param_ack_r <= 1'b0;
         param_refused_r <= 1'b0;
      end else begin
         param_rdata_r <= param_rd ? rsel_w : param_rdata_r;
         param_ack_r <= wr_ok_w || (param_rd && mapped_w);
         param_refused_r <= refuse_w;
      end
   end

   // Filtered levels out
   assign filtered_two = filt_w[0];
   assign filtered_three = filt_w[1];
   assign filtered_four = filt_w[2];
   assign filtered_five = filt_w[3];

   // Port-level checks; a read in the same cycle may acknowledge too
   AST_REFUSE_WHEN_POWERED: assert property (@(posedge clock) disable iff (rst)
      (param_wr && !param_rd && power_stage_en) |=> param_refused_r && !param_ack_r)
      else $error("write under power not refused");
   AST_READ_BACK: assert property (@(posedge clock) disable iff (rst)
      (param_rd && !param_wr && param_addr == DIDB_ADDR_INPUT_FOUR) |=> param_rdata_r == setting_r[2])
      else $error("read of input four setting wrong");

   // Answer checks, one cycle after the strobe
   AST_REFUSE_OUT_OF_RANGE: assert property (@(posedge clock) disable iff (rst)
      (param_wr && !param_rd && param_wdata > DIDB_CODE_MAX) |=> param_refused_r && !param_ack_r)
      else $error("out-of-range write not refused");
   AST_ACK_ON_WRITE: assert property (@(posedge clock) disable iff (rst)
      (param_wr && !param_rd && mapped_w && !power_stage_en && param_wdata <= DIDB_CODE_MAX)
         |=> param_ack_r && !param_refused_r)
      else $error("accepted write not acknowledged");
   AST_MAPPED_READ_ACK: assert property (@(posedge clock) disable iff (rst)
      (param_rd && !param_wr && mapped_w) |=> param_ack_r && !param_refused_r)
      else $error("mapped read not acknowledged");
   AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (rst)
      (param_rd && !param_wr && !mapped_w) |=> param_rdata_r == '0 && param_refused_r && !param_ack_r)
      else $error("unmapped read not refused with zero data");
   AST_NO_ANSWER_IDLE: assert property (@(posedge clock) disable iff (rst)
      (!param_rd && !param_wr) |=> !param_ack_r && !param_refused_r)
      else $error("answer without a strobe");
   // Address table must keep the four settings apart
   AST_ONE_HIT: assert property (@(posedge clock) disable iff (rst)
      $onehot0(hit_w))
      else $error("one address selects more than one setting");
   // Read data stands until the next read
   AST_RDATA_HOLDS: assert property (@(posedge clock) disable iff (rst)
      !param_rd |=> $stable(param_rdata_r))
      else $error("read data changed without a read");
   // Reset clears every answer and every filtered level
   AST_RESET_OUTPUTS: assert property (@(posedge clock)
      rst |=> param_rdata_r == '0 && !param_ack_r && !param_refused_r && filt_w == '0)
      else $error("outputs not cleared by reset");

   // Main scenarios
   COV_WRITE_ACCEPTED: cover property (@(posedge clock) disable iff (rst) wr_ok_w);
   COV_WRITE_OUT_OF_RANGE: cover property (@(posedge clock) disable iff (rst) param_wr && param_wdata > DIDB_CODE_MAX);
   COV_WRITE_LOCKED: cover property (@(posedge clock) disable iff (rst) param_wr && power_stage_en && mapped_w);
   COV_BYPASS_SET: cover property (@(posedge clock) disable iff (rst) setting_r[0] == DIDB_CODE_BYPASS);
   COV_FILTER_FLIP: cover property (@(posedge clock) disable iff (rst) $changed(filtered_two));
endmodule

// ==== tb/didb_switch_model.sv ====
`timescale 1ns/1ps
// External switches: four contacts that hold whatever level they are commanded
module didb_switch_model (
   input wire logic [3:0] level_cmd,
   output logic sw_two,
   output logic sw_three,
   output logic sw_four,
   output logic sw_five
);
   // Contacts are always driven, so no released state exists
   assign sw_two = level_cmd[0];
   assign sw_three = level_cmd[1];
   assign sw_four = level_cmd[2];
   assign sw_five = level_cmd[3];
endmodule

// ==== tb/didb_top_bench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h want %0h", $time, got, exp); end end
module didb_top_bench;
   import didb_pkg::*;
   localparam int STEP = 4;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic power_stage_en = 1'b0;
   logic param_wr = 1'b0;
   logic param_rd = 1'b0;
   logic [DIDB_ADDR_W-1:0] param_addr = 16'h0000;
   logic [DIDB_DATA_W-1:0] param_wdata = 16'h0000;
   logic [DIDB_DATA_W-1:0] param_rdata_r;
   logic param_ack_r;
   logic param_refused_r;
   logic [3:0] level_cmd = 4'h0;
   logic [3:0] filt;
   logic [3:0] pin;
   int error_cnt = 0;
   int num_checks = 0;

   // Free-running 125 MHz clock
   initial begin
      forever #4 clock = ~clock;
   end

   didb_switch_model i_sw (.level_cmd(level_cmd), .sw_two(pin[0]), .sw_three(pin[1]),
      .sw_four(pin[2]), .sw_five(pin[3]));

   // Short step keeps the longest filter time at 24 cycles
   didb_top #(.STEP_CYC(DIDB_CNT_W'(STEP))) i_dut (.clock(clock), .rst(rst), .power_stage_en(power_stage_en),
      .signal_input_two(pin[0]), .signal_input_three(pin[1]), .signal_input_four(pin[2]),
      .signal_input_five(pin[3]), .param_addr(param_addr), .param_wr(param_wr), .param_rd(param_rd),
      .param_wdata(param_wdata), .param_rdata_r(param_rdata_r), .param_ack_r(param_ack_r),
      .param_refused_r(param_refused_r), .filtered_two(filt[0]), .filtered_three(filt[1]),
      .filtered_four(filt[2]), .filtered_five(filt[3]));

   // One parameter access; answer is a one-cycle pulse, so look right after it
   task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] data, input logic ok);
      @(negedge clock);
      param_addr = addr;
      param_wdata = data;
      param_wr = wr;
      param_rd = ~wr;
      @(negedge clock);
      param_wr = 1'b0;
      param_rd = 1'b0;
      `CHK(param_ack_r, ok)
      `CHK(param_refused_r, ~ok)
   endtask

   task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic ok);
      acc(1'b0, addr, 16'h0000, ok);
      `CHK(param_rdata_r, exp)
   endtask

   // Toggle one contact and expect the output exactly lat edges later
   task automatic flip(input int ch, input int lat);
      logic old;
      old = filt[ch];
      @(negedge clock);
      level_cmd[ch] = ~level_cmd[ch];
      repeat (lat - 1) @(negedge clock);
      `CHK(filt[ch], old)
      @(negedge clock);
      `CHK(filt[ch], ~old)
   endtask

   task automatic print_verdict;
      $display("errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (8) @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(DIDB_ADDR_INPUT_TWO + 16'(2 * i), DIDB_SETTING_RESET, 1'b1);
      end
      // Every code, applied live with no restart in between
      for (int k = 0; k <= 6; k++) begin
         acc(1'b1, DIDB_ADDR_INPUT_TWO, 16'(k), 1'b1);
         flip(0, (k == 0) ? 5 : 4 + STEP * k);
      end
      // Pulse shorter than the hold time must vanish
      @(negedge clock);
      level_cmd[0] = ~level_cmd[0];
      repeat (STEP * 6 - 2) @(negedge clock);
      level_cmd[0] = ~level_cmd[0];
      repeat (40) begin
         @(negedge clock);
         `CHK(filt[0], level_cmd[0])
      end
      // Each channel follows its own setting only
      for (int i = 1; i < 4; i++) begin
         acc(1'b1, DIDB_ADDR_INPUT_TWO + 16'(2 * i), 16'(i), 1'b1);
         flip(i, 4 + STEP * i);
      end
      // Locked while the power stage runs; then out-of-range, top-code, unmapped and odd-address accesses
      power_stage_en = 1'b1;
      acc(1'b1, DIDB_ADDR_INPUT_THREE, 16'h0002, 1'b0);
      rd(DIDB_ADDR_INPUT_THREE, 16'h0001, 1'b1);
      power_stage_en = 1'b0;
      acc(1'b1, DIDB_ADDR_INPUT_FOUR, 16'h0007, 1'b0);
      rd(DIDB_ADDR_INPUT_FOUR, 16'h0002, 1'b1);
      acc(1'b1, DIDB_ADDR_INPUT_FIVE, DIDB_CODE_MAX, 1'b1);
      rd(DIDB_ADDR_INPUT_FIVE, DIDB_CODE_MAX, 1'b1);
      rd(16'h084C, 16'h0000, 1'b0);
      acc(1'b1, 16'h0845, 16'h0001, 1'b0);
      print_verdict();
   end
endmodule
